/* hdl/hpsc_top.v */
// Hot-plug slot configuration control with APB register access and per-port slot logic.
//
// The APB register port was chosen for this implementation.
`include "hpsc_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Config bit 0 inverts attention button input of every port.
// - Config bit 1 inverts presence detect input of every port.
// - Config bit 2 inverts power fault input of every port.
// - Config bit 3 inverts latch sensor input of every port.
// - Config bit 4 inverts attention indicator output of every port.
// - Config bit 5 inverts power indicator output of every port.
// - Config bit 6 inverts slot power enable output of every port.
// - Config bit 7 inverts interlock output of every port.
// - Config bit 8 inverts slot power good input of every port.
// - Bit 11, reset one, removes power when latch opens if latch present and bit 12 clear.
// - Bit 12 makes latch inputs report lock state instead of latch status.
// - Bit 13 clear: writing interlock control one pulses interlock for 125 ms.
// - Bit 13 set: writing interlock control one toggles interlock output.
// - Bits 15:14 select reset source: power enable, power good, hot reset.
// - Bits 23:16 give power-stable to reset release delay in 10 ms steps.
// - Power-to-reset delay resets to 0x14, which is 200 ms.
// - Bits 31:24 give reset assertion to power off delay, reset 0x14.
// - Sticky fields survive hot reset; only fundamental reset restores defaults.
module hpsc_top #(
  parameter PORTS = 8,
  parameter STEP_CYCLES = (`HPSC_STEP_NS + `HPSC_CLK_NS - 1) / `HPSC_CLK_NS,
  parameter PULSE_CYCLES = (`HPSC_PULSE_NS + `HPSC_CLK_NS - 1) / `HPSC_CLK_NS
) (
  // Clock and resets.
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_hot_rst,
  // APB slave.
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  // Slot capability.
  input wire [PORTS-1:0] i_latch_present_flag,
  // Slot pins in, raw polarity.
  input wire [PORTS-1:0] i_attention_button_in,
  input wire [PORTS-1:0] i_presence_detect_in,
  input wire [PORTS-1:0] i_power_fault_in,
  input wire [PORTS-1:0] i_latch_sensor_in,
  input wire [PORTS-1:0] i_slot_power_good_in,
  // Slot pins out, pin polarity.
  output reg [PORTS-1:0] o_attention_indicator_out,
  output reg [PORTS-1:0] o_power_indicator_out,
  output reg [PORTS-1:0] o_slot_power_enable_out,
  output reg [PORTS-1:0] o_interlock_out,
  output reg [PORTS-1:0] o_downstream_reset
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and synchronisers.
  reg [31:0] hotplug_config_control;
  reg [PORTS-1:0] power_controller_ctl;
  reg [PORTS-1:0] attn_ind_ctl;
  reg [PORTS-1:0] pwr_ind_ctl;
  reg [PORTS-1:0] sy1_btn, sy2_btn;
  reg [PORTS-1:0] sy1_prs, sy2_prs;
  reg [PORTS-1:0] sy1_flt, sy2_flt;
  reg [PORTS-1:0] sy1_lat, sy2_lat;
  reg [PORTS-1:0] sy1_pgd, sy2_pgd;
  reg [PORTS-1:0] sensed_btn, sensed_prs, sensed_flt, sensed_lat, sensed_pgd;
  wire [PORTS-1:0] pwr_on, rst_active, ilk;
  wire wr_en;
  wire rd_en;
  wire ilk_wr;
  wire addr_ok;

  // Polarity fix: XOR a level with a broadcast invert bit.
  function [PORTS-1:0] hpsc_pol;
    input [PORTS-1:0] val;
    input inv;
    begin
      hpsc_pol = val ^ {PORTS{inv}};
    end
  endfunction

  // Places a per-port vector in the low bits of one byte lane, spare ports read zero.
  function [7:0] hpsc_lane;
    input [PORTS-1:0] val;
    begin
      hpsc_lane = 8'h00;
      hpsc_lane[PORTS-1:0] = val;
    end
  endfunction

  // Takes the per-port bits from the low end of one byte lane; bits of absent ports are dropped.
  function [PORTS-1:0] hpsc_field;
    input [7:0] lane;
    begin
      hpsc_field = lane[PORTS-1:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, unmapped addresses answer with an error.
  assign addr_ok = (i_paddr == `HPSC_CFG_ADDR) || (i_paddr == `HPSC_SLOT_CTL_ADDR) ||
                   (i_paddr == `HPSC_SLOT_STS_ADDR);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign ilk_wr = wr_en && (i_paddr == `HPSC_SLOT_CTL_ADDR);

  // Configuration register: every field is sticky, restored to its reset value only by the system reset.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      hotplug_config_control <= `HPSC_CFG_RESET;
    end else if (wr_en && i_paddr == `HPSC_CFG_ADDR) begin
      hotplug_config_control <= i_pwdata & `HPSC_CFG_WMASK;
    end
  end

  // Slot control register: power, indicators; hot reset drops slot power requests.
  always @(posedge i_clk) begin
    if (i_sys_rst || i_hot_rst) begin
      power_controller_ctl <= {PORTS{1'b0}};
      attn_ind_ctl <= {PORTS{1'b0}};
      pwr_ind_ctl <= {PORTS{1'b0}};
    end else if (ilk_wr) begin
      power_controller_ctl <= hpsc_field(i_pwdata[`HPSC_SC_PWR]);
      attn_ind_ctl <= hpsc_field(i_pwdata[`HPSC_SC_AIND]);
      pwr_ind_ctl <= hpsc_field(i_pwdata[`HPSC_SC_PIND]);
    end
  end

  // Read data is captured in the setup phase and held for the access phase.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (i_paddr)
        `HPSC_CFG_ADDR: o_prdata <= hotplug_config_control;
        `HPSC_SLOT_CTL_ADDR: o_prdata <= {8'h00, hpsc_lane(pwr_ind_ctl), hpsc_lane(attn_ind_ctl),
                                          hpsc_lane(power_controller_ctl)};
        `HPSC_SLOT_STS_ADDR: o_prdata <= {hpsc_lane(sensed_pgd), hpsc_lane(sensed_lat),
                                          hpsc_lane(sensed_prs | sensed_flt), hpsc_lane(sensed_btn)};
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for slot pins.
  always @(posedge i_clk) begin
    sy1_btn <= i_attention_button_in;
    sy2_btn <= sy1_btn;
    sy1_prs <= i_presence_detect_in;
    sy2_prs <= sy1_prs;
    sy1_flt <= i_power_fault_in;
    sy2_flt <= sy1_flt;
    sy1_lat <= i_latch_sensor_in;
    sy2_lat <= sy1_lat;
    sy1_pgd <= i_slot_power_good_in;
    sy2_pgd <= sy1_pgd;
  end

  // Sensed input levels after polarity correction.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sensed_btn <= {PORTS{1'b0}};
      sensed_prs <= {PORTS{1'b0}};
      sensed_flt <= {PORTS{1'b0}};
      sensed_lat <= {PORTS{1'b0}};
      sensed_pgd <= {PORTS{1'b0}};
    end else begin
      sensed_btn <= hpsc_pol(sy2_btn, hotplug_config_control[`HPSC_B_INV_BTN]);
      sensed_prs <= hpsc_pol(sy2_prs, hotplug_config_control[`HPSC_B_INV_PRS]);
      sensed_flt <= hpsc_pol(sy2_flt, hotplug_config_control[`HPSC_B_INV_FLT]);
      sensed_lat <= hpsc_pol(sy2_lat, hotplug_config_control[`HPSC_B_INV_LAT]);
      sensed_pgd <= hpsc_pol(sy2_pgd, hotplug_config_control[`HPSC_B_INV_PGD]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-port sequencers.
  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1) begin : g_port
      hpsc_port #(
        .STEP_CYCLES(STEP_CYCLES),
        .PULSE_CYCLES(PULSE_CYCLES)
      ) u_port (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_hot_rst(i_hot_rst),
        .i_mode(hotplug_config_control[`HPSC_F_RST_MODE]),
        .i_p2r(hotplug_config_control[`HPSC_F_P2R]),
        .i_r2p(hotplug_config_control[`HPSC_F_R2P]),
        .i_auto_off(hotplug_config_control[`HPSC_B_AUTO_OFF]),
        .i_latch_present(i_latch_present_flag[g]),
        .i_lock_sts(hotplug_config_control[`HPSC_B_LOCK_STS]),
        .i_toggle(hotplug_config_control[`HPSC_B_TOGGLE]),
        .i_pwr_req(power_controller_ctl[g]),
        .i_latch_open(sensed_lat[g]),
        .i_pwr_good(sensed_pgd[g]),
        .i_ilk_write(ilk_wr & i_pwdata[`HPSC_SC_ILK_LANE + g]),
        .o_pwr_on(pwr_on[g]),
        .o_rst_active(rst_active[g]),
        .o_ilk(ilk[g])
      );
    end
  endgenerate

  // Output pins with polarity selection; downstream reset has none.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_attention_indicator_out <= {PORTS{1'b0}};
      o_power_indicator_out <= {PORTS{1'b0}};
      o_slot_power_enable_out <= {PORTS{1'b0}};
      o_interlock_out <= {PORTS{1'b0}};
      o_downstream_reset <= {PORTS{1'b1}};
    end else begin
      o_attention_indicator_out <= hpsc_pol(attn_ind_ctl, hotplug_config_control[`HPSC_B_INV_AIND]);
      o_power_indicator_out <= hpsc_pol(pwr_ind_ctl, hotplug_config_control[`HPSC_B_INV_PIND]);
      o_slot_power_enable_out <= hpsc_pol(pwr_on, hotplug_config_control[`HPSC_B_INV_PEN]);
      o_interlock_out <= hpsc_pol(ilk, hotplug_config_control[`HPSC_B_INV_ILK]);
      o_downstream_reset <= rst_active;
    end
  end

endmodule

/* hdl/hpsc_map.vh */
// Register map, field positions, reset values and timing constants for the hot-plug slot configuration block.
`ifndef HPSC_MAP_VH
`define HPSC_MAP_VH
// Register byte offsets.
`define HPSC_CFG_ADDR 12'h408
`define HPSC_SLOT_CTL_ADDR 12'h410
`define HPSC_SLOT_STS_ADDR 12'h414
// Field positions in the configuration register.
`define HPSC_B_INV_BTN 0
`define HPSC_B_INV_PRS 1
`define HPSC_B_INV_FLT 2
`define HPSC_B_INV_LAT 3
`define HPSC_B_INV_AIND 4
`define HPSC_B_INV_PIND 5
`define HPSC_B_INV_PEN 6
`define HPSC_B_INV_ILK 7
`define HPSC_B_INV_PGD 8
`define HPSC_B_AUTO_OFF 11
`define HPSC_B_LOCK_STS 12
`define HPSC_B_TOGGLE 13
`define HPSC_F_RST_MODE 15:14
`define HPSC_F_P2R 23:16
`define HPSC_F_R2P 31:24
// Writable bits of the configuration register and its reset value.
`define HPSC_CFG_WMASK 32'hFFFFFFFF
`define HPSC_CFG_RESET 32'h14140800
// Reset mode codes.
`define HPSC_MODE_PEC 2'h0
`define HPSC_MODE_PGC 2'h1
`define HPSC_MODE_HOT 2'h2
// Slot control register fields, one bit per port in each byte lane.
`define HPSC_SC_PWR 7:0
`define HPSC_SC_AIND 15:8
`define HPSC_SC_PIND 23:16
`define HPSC_SC_ILK_LANE 24
// Timing: one delay step and the interlock pulse.
`define HPSC_STEP_NS 10000000
`define HPSC_PULSE_NS 125000000
`define HPSC_CLK_NS 100
`endif

/* hdl/hpsc_port.v */
// Per-port power, reset sequencing and interlock logic for one downstream slot.
`include "hpsc_map.vh"

module hpsc_port #(
  parameter STEP_CYCLES = 100000,
  parameter PULSE_CYCLES = 1250000
) (
  // Clock and resets.
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_hot_rst,
  // Configuration.
  input wire [1:0] i_mode,
  input wire [7:0] i_p2r,
  input wire [7:0] i_r2p,
  input wire i_auto_off,
  input wire i_latch_present,
  input wire i_lock_sts,
  input wire i_toggle,
  // Slot request and sensed state, true polarity.
  input wire i_pwr_req,
  input wire i_latch_open,
  input wire i_pwr_good,
  input wire i_ilk_write,
  // Outputs, true polarity.
  output reg o_pwr_on,
  output reg o_rst_active,
  output reg o_ilk
);

  localparam ST_OFF = 2'h0;
  localparam ST_WAIT_RLS = 2'h1;
  localparam ST_ON = 2'h2;
  localparam ST_WAIT_OFF = 2'h3;

  reg [1:0] state;
  reg [7:0] steps;
  reg [31:0] tick;
  reg [31:0] pulse;
  wire want_on;
  wire stable;
  wire step_end;

  // Latch-open power off only when latch reports status, not lock state.
  assign want_on = i_pwr_req & ~(i_auto_off & i_latch_present & ~i_lock_sts & i_latch_open);
  assign stable = (i_mode == `HPSC_MODE_PGC) ? i_pwr_good : o_pwr_on;
  assign step_end = (tick == STEP_CYCLES - 1);

  // Power and reset sequencer with delays in 10 ms steps.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_OFF;
      steps <= 8'h00;
      tick <= 32'h0;
      o_pwr_on <= 1'b0;
      o_rst_active <= 1'b1;
    end else begin
      tick <= (step_end || state == ST_OFF || state == ST_ON) ? 32'h0 : tick + 32'h1;
      case (state)
        ST_OFF: begin
          o_rst_active <= 1'b1;
          if (want_on) begin
            o_pwr_on <= 1'b1;
            steps <= i_p2r;
            state <= ST_WAIT_RLS;
          end
        end
        ST_WAIT_RLS: begin
          if (!want_on) begin
            state <= ST_WAIT_OFF;
            steps <= 8'h00;
          end else if (!stable) begin
            steps <= i_p2r;
          end else if (steps == 8'h00) begin
            o_rst_active <= (i_mode == `HPSC_MODE_HOT) ? i_hot_rst : 1'b0;
            state <= ST_ON;
          end else if (step_end) begin
            steps <= steps - 8'h01;
          end
        end
        ST_ON: begin
          if (i_mode == `HPSC_MODE_HOT) begin
            o_rst_active <= i_hot_rst;
          end else if (i_mode == `HPSC_MODE_PGC && !i_pwr_good) begin
            o_rst_active <= 1'b1;
          end
          if (!want_on) begin
            o_rst_active <= 1'b1;
            steps <= i_r2p;
            state <= ST_WAIT_OFF;
          end
        end
        ST_WAIT_OFF: begin
          if (steps == 8'h00) begin
            o_pwr_on <= 1'b0;
            state <= ST_OFF;
          end else if (step_end) begin
            steps <= steps - 8'h01;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // Interlock: pulse for a fixed time or toggle on each write of one.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ilk <= 1'b0;
      pulse <= 32'h0;
    end else if (i_ilk_write && i_toggle) begin
      o_ilk <= ~o_ilk;
      pulse <= 32'h0;
    end else if (i_ilk_write) begin
      o_ilk <= 1'b1;
      pulse <= PULSE_CYCLES;
    end else if (pulse != 32'h0) begin
      pulse <= pulse - 32'h1;
      if (pulse == 32'h1) begin
        o_ilk <= 1'b0;
      end
    end
  end

endmodule

/* sim/hpsc_check_assertions.sv */
// Concurrent checks of the hot-plug slot configuration block at its top-level ports.
`include "hpsc_map.vh"
module hpsc_check #(
  parameter PORTS = 8,
  parameter STEP_CYCLES = 4,
  parameter PULSE_CYCLES = 10
) (
  // Clock and reset.
  input wire i_clk,
  input wire i_sys_rst,
  // APB.
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [31:0] o_prdata,
  // Slot outputs.
  input wire [PORTS-1:0] o_slot_power_enable_out,
  input wire [PORTS-1:0] o_interlock_out,
  input wire [PORTS-1:0] o_downstream_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [31:0] cfg;
  logic [2:0] qcnt;
  logic [2:0] wcnt;
  int on_cnt;
  wire acc = i_psel && i_penable;
  wire mapped = i_paddr == `HPSC_CFG_ADDR || i_paddr == `HPSC_SLOT_CTL_ADDR || i_paddr == `HPSC_SLOT_STS_ADDR;
  wire pwr0 = o_slot_power_enable_out[0] ^ cfg[6];
  wire ilk0 = o_interlock_out[0] ^ cfg[7];
  wire quiet = qcnt == 3'h7;
  wire mode0 = cfg[15:14] == 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the configuration and cycle counters since writes and power-on.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg <= `HPSC_CFG_RESET;
      qcnt <= 3'h0;
      wcnt <= 3'h0;
      on_cnt <= 0;
    end else begin
      if (acc && i_pwrite && i_paddr == `HPSC_CFG_ADDR) begin
        cfg <= i_pwdata;
        qcnt <= 3'h0;
      end else if (!quiet) begin
        qcnt <= qcnt + 3'h1;
      end
      if (acc && i_pwrite && i_paddr == `HPSC_SLOT_CTL_ADDR) wcnt <= 3'h0;
      else if (wcnt != 3'h7) wcnt <= wcnt + 3'h1;
      on_cnt <= pwr0 ? on_cnt + 1 : 0;
    end
  end
  sequence rst_held;
    i_sys_rst ##1 i_sys_rst;
  endsequence
  sequence ilk_pulse_start;
    $rose(ilk0) && quiet && !cfg[13];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  pready_high_a: assert property (o_pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !mapped |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !o_pslverr) else $error("mapped access refused");
  cfg_read_a:
    assert property (acc && !i_pwrite && i_paddr == `HPSC_CFG_ADDR |-> o_prdata == cfg) else $error("config read wrong");
  reset_out_a:
    assert property (@(posedge i_clk) disable iff (1'b0) rst_held |-> &o_downstream_reset && o_slot_power_enable_out == '0)
    else $error("outputs not in reset state");
  pec_reset_a:
    assert property (quiet && mode0 && !pwr0 |-> o_downstream_reset[0]) else $error("reset released while unpowered");
  release_delay_a:
    assert property ($fell(o_downstream_reset[0]) && quiet && mode0 |-> on_cnt >= cfg[23:16] * STEP_CYCLES)
    else $error("reset released too early");
  ilk_pulse_a:
    assert property (ilk_pulse_start |-> ilk0 [*8] ##[1:4] !ilk0) else $error("interlock pulse width wrong");
  ilk_hold_a:
    assert property (quiet && cfg[13] && wcnt == 3'h7 |-> $stable(o_interlock_out[0])) else $error("interlock moved unasked");
endmodule
bind hpsc_top hpsc_check #(.PORTS(PORTS), .STEP_CYCLES(STEP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) hpsc_check_i (
  .i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
  .o_prdata, .o_slot_power_enable_out, .o_interlock_out, .o_downstream_reset);

/* sim/hpsc_slot_model.sv */
// Slot hardware model: power supply answering the enable pin and a latch sensor.
module hpsc_slot_model #(
  parameter int DELAY = 2
) (
  input wire logic i_clk,
  input wire logic [1:0] i_pen_pin,
  input wire logic [31:0] i_cfg,
  input wire logic [1:0] i_latch_open,
  output logic [1:0] o_pgood_pin,
  output logic [1:0] o_latch_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] hist = 16'h0;
  // Power good follows the true enable a few cycles late, as a real supply ramps.
  always @(posedge i_clk) begin
    hist <= {hist[13:0], i_pen_pin ^ {2{i_cfg[6]}}};
  end
  assign o_pgood_pin = hist[2*DELAY-1 -: 2] ^ {2{i_cfg[8]}};
  assign o_latch_pin = i_latch_open ^ {2{i_cfg[3]}};
endmodule

/* sim/hpsc_top_tb.sv */
// Self-checking testbench of the hot-plug slot configuration block.
module hpsc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] cfg, sctl; logic [1:0] btn, prs, flt, aind, pind; logic [31:0] sts;} hpsc_row_t;
  logic i_clk = 0, i_sys_rst = 1, i_hot_rst = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, cfg_now = 32'h14140800, rd;
  logic [1:0] lflag = 0, btn = 0, prs = 0, flt = 0, lopen = 0;
  wire [1:0] pgood_pin, latch_pin, aind, pind, pen, ilk, drst;
  wire pready, pslverr;
  wire [31:0] prdata;
  int miscompares = 0, n_compared = 0, n;
  hpsc_row_t rows [5];
  hpsc_top #(.PORTS(2), .STEP_CYCLES(4), .PULSE_CYCLES(10)) hpsc_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_hot_rst(i_hot_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_latch_present_flag(lflag),
    .i_attention_button_in(btn), .i_presence_detect_in(prs), .i_power_fault_in(flt), .i_latch_sensor_in(latch_pin),
    .i_slot_power_good_in(pgood_pin), .o_attention_indicator_out(aind), .o_power_indicator_out(pind),
    .o_slot_power_enable_out(pen), .o_interlock_out(ilk), .o_downstream_reset(drst));
  hpsc_slot_model hpsc_slot_model_i (.i_clk(i_clk), .i_pen_pin(pen), .i_cfg(cfg_now), .i_latch_open(lopen),
    .o_pgood_pin(pgood_pin), .o_latch_pin(latch_pin));
  ////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 100 ns.
  always #50 i_clk = ~i_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    do begin
      @(posedge i_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    if (w && a == 12'h408) cfg_now <= d;
    psel <= 0;
    penable <= 0;
  endtask
  task end_of_test;
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: table of polarity cases, then hand-written sequences.
  initial begin
    rows[0] = '{32'h14140800, 32'h00010200, 2'h1, 2'h0, 2'h0, 2'h2, 2'h1, 32'h00000001};
    rows[1] = '{32'h1414083F, 32'h00010200, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 32'h00000302};
    rows[2] = '{32'h14144906, 32'h00010200, 2'h2, 2'h1, 2'h3, 2'h2, 2'h1, 32'h00000202};
    rows[3] = '{32'h0000C600, 32'h00000000, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 32'h00000303};
    rows[4] = '{32'h00008000, 32'h00030300, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 32'h00000200};
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 0;
    apb(0, 12'h408, 0);
    chk(rd, 32'h14140800);
    chk(drst, 2'h3);
    foreach (rows[i]) begin
      btn <= rows[i].btn;
      prs <= rows[i].prs;
      flt <= rows[i].flt;
      apb(1, 12'h408, rows[i].cfg);
      apb(1, 12'h410, rows[i].sctl);
      repeat (6) @(posedge i_clk);
      apb(0, 12'h414, 0);
      chk(rd, rows[i].sts);
      chk({aind, pind}, {rows[i].aind, rows[i].pind});
      apb(0, 12'h408, 0);
      chk(rd, rows[i].cfg);
    end
    apb(1, 12'h40C, 32'hFFFFFFFF);
    chk(err, 1);
    apb(0, 12'h40C, 0);
    chk(rd, 0);
    apb(0, 12'h408, 0);
    chk(rd, 32'h00008000);
    apb(1, 12'h408, 32'h02030040);
    repeat (8) @(posedge i_clk);
    chk(pen, 2'h3);
    apb(1, 12'h410, 32'h1);
    n = 0;
    while (drst[0] !== 1'b0 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    chk(pen, 2'h2);
    chk(n >= 12 && n <= 20, 1);
    apb(1, 12'h410, 0);
    n = 0;
    while (pen[0] !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    chk(drst[0], 1);
    chk(n >= 8 && n <= 16, 1);
    lflag <= 2'h1;
    apb(1, 12'h408, 32'h00000800);
    apb(1, 12'h410, 32'h1);
    repeat (20) @(posedge i_clk);
    chk(pen[0], 1);
    lopen <= 2'h1;
    repeat (20) @(posedge i_clk);
    chk(pen[0], 0);
    apb(1, 12'h408, 32'h00001800);
    apb(1, 12'h410, 32'h1);
    repeat (20) @(posedge i_clk);
    chk(pen[0], 1);
    lopen <= 0;
    lflag <= 0;
    apb(1, 12'h410, 0);
    apb(1, 12'h408, 0);
    repeat (8) @(posedge i_clk);
    apb(1, 12'h410, 32'h01000000);
    n = 0;
    while (ilk[0] !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      n++;
    end
    n = 0;
    while (ilk[0] === 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    chk(n >= 9 && n <= 11, 1);
    apb(1, 12'h408, 32'h00002080);
    repeat (8) @(posedge i_clk);
    chk(ilk, 2'h3);
    apb(1, 12'h410, 32'h02000000);
    repeat (4) @(posedge i_clk);
    chk(ilk, 2'h1);
    apb(1, 12'h410, 32'h02000000);
    repeat (4) @(posedge i_clk);
    chk(ilk, 2'h3);
    apb(1, 12'h408, 32'h5A5A0A55);
    i_hot_rst <= 1;
    repeat (3) @(posedge i_clk);
    i_hot_rst <= 0;
    apb(0, 12'h408, 0);
    chk(rd, 32'h5A5A0A55);
    i_sys_rst <= 1;
    cfg_now <= 32'h14140800;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 0;
    apb(0, 12'h408, 0);
    chk(rd, 32'h14140800);
    end_of_test;
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_of_test;
  end
endmodule
